// File: link_regs_asserts.sv
/* Port assertions for the link register bank.
   Bound from the testbench top; one clock, async active-low reset. */
`timescale 1ns/1ns
module link_regs_asserts
  import link_regs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Bus
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Link side
  input wire link_ctl_t [NUM_PORTS-1:0] link_ctl_o,
  input wire logic [NUM_PORTS-1:0] rx_l0s_allowed_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic rd_ok;
  assign rd_ok = avs_read_i & !avs_waitrequest_o;
  a_wait_one: assert property ($rose(avs_read_i | avs_write_i) |->
    avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("bus answer late");
  a_l0s_always: assert property (rx_l0s_allowed_o == 3'h7) else $error("l0s");
  a_up_fixed: assert property (!link_ctl_o[0].link_disable && !link_ctl_o[0].retrain
    && link_ctl_o[0].spare == 2'h0) else $error("upstream ctl");
  a_retrain_pulse: assert property (link_ctl_o[1].retrain |=> !link_ctl_o[1].retrain)
    else $error("retrain long");
  a_retrain_cause: assert property ($rose(link_ctl_o[2].retrain) |-> $past(avs_write_i
    && !avs_waitrequest_o && avs_address_i == 10'h2d0 && avs_writedata_i[5]))
    else $error("retrain cause");
  a_xsync_counts: assert property (link_ctl_o[1].ext_sync |->
    link_ctl_o[1].fts_count == 13'h1000 && link_ctl_o[1].ts1_count == 13'h0400)
    else $error("sync counts");
  a_ctl_rd_zero: assert property (rd_ok && avs_address_i[7:0] == 8'hd0 |->
    avs_readdata_o[5] == 1'b0 && avs_readdata_o[3] == 1'b0) else $error("ctl zero bits");
  a_unmapped_zero: assert property (rd_ok && avs_address_i[9:8] == 2'h3 |->
    avs_readdata_o == 32'h0000_0000) else $error("unmapped read");
endmodule : link_regs_asserts

// File: link_regs_pkg.sv
/*
 * Package for the per-port link capability and link control register bank:
 * offsets, field positions, reset values, load masks and carrier types.
 * Assumes a three-port switch with port 0 upstream and ports 1 and 2 downstream.
 */
package link_regs_pkg;

  localparam int NUM_PORTS = 3;
  localparam int ADDR_W = 10;

  // Byte addresses; each port owns one 256-byte window
  localparam logic [7:0] OFS_LINK_CAP = 8'hcc;
  localparam logic [7:0] OFS_LINK_CTL = 8'hd0;

  // Capability field positions
  localparam int CAP_SPEED_LSB = 0;
  localparam int CAP_WIDTH_LSB = 4;
  localparam int CAP_ASPM_LSB = 10;
  localparam int CAP_L0S_LSB = 12;
  localparam int CAP_L1_LSB = 15;
  localparam int CAP_CLKPM_BIT = 18;
  localparam int CAP_SDOWN_BIT = 19;
  localparam int CAP_DLACT_BIT = 20;
  localparam int CAP_BWN_BIT = 21;
  localparam int CAP_PORT_LSB = 24;

  localparam logic [3:0] SPEED_2G5 = 4'h1;
  localparam logic [3:0] SPEED_5G0 = 4'h2;
  localparam logic [5:0] WIDTH_X1 = 6'h01;
  localparam logic [1:0] ASPM_SUP_BOTH = 2'h3;
  localparam logic [2:0] L0S_LAT_256NS = 3'h3;
  localparam logic [2:0] L1_LAT_16US = 3'h0;

  // Fields that the SMBus or EEPROM path may overwrite
  localparam logic [31:0] CAP_LOAD_MASK = 32'hff07_fc00;

  // Control field positions
  localparam int CTL_ASPM_LSB = 0;
  localparam int CTL_RCB_BIT = 3;
  localparam int CTL_DIS_BIT = 4;
  localparam int CTL_RETRAIN_BIT = 5;
  localparam int CTL_CCLK_BIT = 6;
  localparam int CTL_XSYNC_BIT = 7;
  localparam int CTL_HAWD_BIT = 9;
  localparam int CTL_B10_BIT = 10;
  localparam int CTL_B11_BIT = 11;
  localparam int STA_TRAIN_BIT = 27;

  // Stored control bits per port kind
  localparam logic [15:0] CTL_WMASK_UP = 16'h02c3;
  localparam logic [15:0] CTL_WMASK_DN = 16'h0ed3;
  localparam logic [15:0] CTL_RESET = 16'h0000;

  // Ordered-set counts when extended sync is set
  localparam logic [12:0] XSYNC_FTS = 13'h1000;
  localparam logic [12:0] XSYNC_TS1 = 13'h0400;

  typedef struct packed {
    logic [1:0] aspm_en;
    logic link_disable;
    logic retrain;
    logic common_clk;
    logic ext_sync;
    logic hw_width_dis;
    logic [1:0] spare;
    logic [12:0] fts_count;
    logic [12:0] ts1_count;
  } link_ctl_t;

  typedef struct packed {
    logic valid;
    logic [1:0] port;
    logic [31:0] data;
  } cap_load_t;

  function automatic logic [31:0] cap_default(input int p);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[CAP_SPEED_LSB +: 4] = SPEED_5G0;
    v[CAP_WIDTH_LSB +: 6] = WIDTH_X1;
    v[CAP_ASPM_LSB +: 2] = ASPM_SUP_BOTH;
    v[CAP_L0S_LSB +: 3] = L0S_LAT_256NS;
    v[CAP_L1_LSB +: 3] = L1_LAT_16US;
    v[CAP_CLKPM_BIT] = (p == 0);
    v[CAP_SDOWN_BIT] = (p != 0);
    v[CAP_DLACT_BIT] = 1'b0;
    v[CAP_BWN_BIT] = (p != 0);
    v[CAP_PORT_LSB +: 8] = 8'(p);
    return v;
  endfunction : cap_default

endpackage : link_regs_pkg

// File: pcie_link_cap_ctrl_regs.sv
/*
 * Link capability and link control registers of a three-port switch,
 * reached over an Avalon-MM slave with waitrequest.
 * Assumes the load path and training logic run on ref_clk_i.
 */
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
module pcie_link_cap_ctrl_regs
  import link_regs_pkg::*;
#(
  parameter logic [12:0] NORMAL_FTS = 13'h00ff,
  parameter logic [12:0] NORMAL_TS1 = 13'h0010
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Capability default load path
  input wire cap_load_t cap_load_i,
  // Link training status per port
  input wire logic [NUM_PORTS-1:0] train_start_i,
  input wire logic [NUM_PORTS-1:0] train_done_i,
  // Controls to link training logic
  output link_ctl_t [NUM_PORTS-1:0] link_ctl_o,
  output logic [NUM_PORTS-1:0] rx_l0s_allowed_o
);

  typedef struct packed {
    logic [NUM_PORTS-1:0][31:0] cap;
    logic [NUM_PORTS-1:0][15:0] ctl;
    logic [NUM_PORTS-1:0] training;
    logic [NUM_PORTS-1:0] retrain;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  function automatic state_t reset_state();
    state_t s;
    s = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      s.cap[p] = cap_default(p);
      s.ctl[p] = CTL_RESET;
    end
    return s;
  endfunction : reset_state

  localparam state_t ST_RESET = reset_state();

  state_t st_r;
  state_t st_nxt;

  logic req;
  logic [1:0] sel_port;
  logic [7:0] sel_ofs;
  logic port_ok;
  logic [15:0] wmask;
  logic [15:0] be_mask;

  assign req = avs_read_i | avs_write_i;
  assign sel_port = avs_address_i[9:8];
  assign sel_ofs = avs_address_i[7:0];
  assign port_ok = (sel_port < 2'(NUM_PORTS));
  assign be_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  always_comb begin
    st_nxt = st_r;
    st_nxt.retrain = '0;
    st_nxt.ack = req & ~st_r.ack;
    wmask = (sel_port == 2'd0) ? CTL_WMASK_UP : CTL_WMASK_DN;

    // Read data captured one cycle before the answer
    if (req & ~st_r.ack) begin
      st_nxt.rdata = 32'h0000_0000;
      if (port_ok && sel_ofs == OFS_LINK_CAP) begin
        st_nxt.rdata = st_r.cap[sel_port];
      end else if (port_ok && sel_ofs == OFS_LINK_CTL) begin
        st_nxt.rdata[15:0] = st_r.ctl[sel_port];
        st_nxt.rdata[STA_TRAIN_BIT] = st_r.training[sel_port];
      end
    end

    // Write takes effect at the answering edge
    if (avs_write_i && st_r.ack && port_ok && sel_ofs == OFS_LINK_CTL) begin
      st_nxt.ctl[sel_port] = (st_r.ctl[sel_port] & ~(wmask & be_mask))
                             | (avs_writedata_i[15:0] & wmask & be_mask);
      if (sel_port != 2'd0 && avs_byteenable_i[0]
          && avs_writedata_i[CTL_RETRAIN_BIT]) begin
        st_nxt.retrain[sel_port] = 1'b1;
      end
    end

    // SMBus or EEPROM default load
    if (cap_load_i.valid && cap_load_i.port < 2'(NUM_PORTS)) begin
      st_nxt.cap[cap_load_i.port] = (st_r.cap[cap_load_i.port] & ~CAP_LOAD_MASK)
                                     | (cap_load_i.data & CAP_LOAD_MASK);
    end

    // Start wins over completion
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (train_done_i[p]) begin
        st_nxt.training[p] = 1'b0;
      end
      if (train_start_i[p] || st_nxt.retrain[p]) begin
        st_nxt.training[p] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_waitrequest_o = req & ~st_r.ack;
  assign avs_readdata_o = st_r.rdata;

  generate
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      assign link_ctl_o[p].aspm_en = st_r.ctl[p][CTL_ASPM_LSB +: 2];
      assign link_ctl_o[p].link_disable = st_r.ctl[p][CTL_DIS_BIT];
      assign link_ctl_o[p].retrain = st_r.retrain[p];
      assign link_ctl_o[p].common_clk = st_r.ctl[p][CTL_CCLK_BIT];
      assign link_ctl_o[p].ext_sync = st_r.ctl[p][CTL_XSYNC_BIT];
      assign link_ctl_o[p].hw_width_dis = st_r.ctl[p][CTL_HAWD_BIT];
      assign link_ctl_o[p].spare = st_r.ctl[p][CTL_B11_BIT:CTL_B10_BIT];
      assign link_ctl_o[p].fts_count = st_r.ctl[p][CTL_XSYNC_BIT] ? XSYNC_FTS
                                       : NORMAL_FTS;
      assign link_ctl_o[p].ts1_count = st_r.ctl[p][CTL_XSYNC_BIT] ? XSYNC_TS1
                                       : NORMAL_TS1;
      assign rx_l0s_allowed_o[p] = 1'b1;
    end
  endgenerate

endmodule : pcie_link_cap_ctrl_regs

// File: testbench.sv
/* Self-checking bench for the link register bank.
   Assumes the partner model as training logic. */
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench
  import link_regs_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, wq;
  logic [9:0] adr = 10'h000;
  logic [31:0] wd = 32'h0000_0000, rdat;
  logic [3:0] be = 4'h0;
  cap_load_t ld = '0;
  logic [2:0] ts, td, l0s;
  link_ctl_t [2:0] lc;
  int err_count = 0, check_count = 0;
  always #2 clk = ~clk;
  pcie_link_cap_ctrl_regs uut(.ref_clk_i(clk), .resetn_i(rstn), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .cap_load_i(ld), .train_start_i(ts),
    .train_done_i(td), .link_ctl_o(lc), .rx_l0s_allowed_o(l0s));
  train_partner tp(.ref_clk_i(clk), .resetn_i(rstn), .link_ctl_i(lc), .train_start_o(ts),
    .train_done_o(td));
  function automatic logic [31:0] cap_exp(int p);
    return 32'h0000_3c12 | (p == 0 ? 32'h0004_0000 : 32'h0028_0000) | (p << 24);
  endfunction : cap_exp
  task automatic bus(logic w, logic [9:0] a, logic [31:0] d, logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    do @(posedge clk); while (wq !== 1'b0 && ++n < 40);
    `CHK(wq, 1'b0)
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic t_reset;
    for (int p = 0; p < 3; p++) begin
      bus(0, {2'(p), 8'hcc}, '0, 4'hf);
      `CHK(rdat, cap_exp(p))
      bus(0, {2'(p), 8'hd0}, '0, 4'hf);
      `CHK(rdat, 32'h0000_0000)
    end
  endtask : t_reset
  task automatic t_ctl;
    for (int p = 0; p < 3; p++) begin
      bus(1, {2'(p), 8'hd0}, 32'h0000_ffff, 4'hf);
      bus(0, {2'(p), 8'hd0}, '0, 4'hf);
      `CHK(rdat, p ? 32'h0800_0ed3 : 32'h0000_02c3)
    end
    `CHK({lc[1].link_disable, lc[2].fts_count, lc[2].ts1_count}, 27'h600_0400)
    `CHK({lc[2].common_clk, lc[2].ext_sync, lc[2].hw_width_dis, lc[2].spare, lc[0].spare}, 7'h7c)
    repeat (60) @(posedge clk);
    bus(1, 10'h1d0, '0, 4'hf);
    // Training start trails the disable release by one edge, the training status bit by two
    repeat (2) @(posedge clk);
    bus(0, 10'h1d0, '0, 4'hf);
    `CHK(rdat, 32'h0800_0000)
    bus(1, 10'h2d0, '0, 4'h2);
    bus(0, 10'h2d0, '0, 4'hf);
    `CHK(rdat, 32'h0000_00d3)
  endtask : t_ctl
  task automatic t_aspm;
    for (int c = 0; c < 4; c++) begin
      bus(1, 10'h2d0, 32'(c), 4'h1);
      @(negedge clk);
      `CHK({lc[2].aspm_en, l0s}, {2'(c), 3'h7})
    end
  endtask : t_aspm
  task automatic t_load;
    @(posedge clk);
    ld <= '{1'b1, 2'h1, 32'hffff_ffff};
    @(posedge clk);
    ld <= '0;
    bus(0, 10'h1cc, '0, 4'hf);
    `CHK(rdat, CAP_LOAD_MASK | (cap_exp(1) & ~CAP_LOAD_MASK))
    bus(1, 10'h2cc, '0, 4'hf);
    bus(0, 10'h2cc, '0, 4'hf);
    `CHK(rdat, cap_exp(2))
    bus(0, 10'h3cc, '0, 4'hf);
    `CHK(rdat, 32'h0000_0000)
  endtask : t_load
  task automatic close_out;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_ctl();
    t_aspm();
    t_load();
    close_out();
  end
  initial begin
    #40000;
    err_count++;
    close_out();
  end
endmodule : testbench
bind pcie_link_cap_ctrl_regs link_regs_asserts chk(.ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .link_ctl_o(link_ctl_o), .rx_l0s_allowed_o(rx_l0s_allowed_o));

// File: train_partner.sv
/* Model of the per-port link training logic.
   Assumes one-cycle retrain pulses and a level link_disable from the bank. */
`timescale 1ns/1ns
module train_partner
  import link_regs_pkg::*;
#(
  parameter int DLY = 50
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Controls in
  input wire link_ctl_t [NUM_PORTS-1:0] link_ctl_i,
  // Status out
  output logic [NUM_PORTS-1:0] train_start_o,
  output logic [NUM_PORTS-1:0] train_done_o
);
  int cnt [NUM_PORTS];
  logic [NUM_PORTS-1:0] dis_q;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= '{default: 0};
      dis_q <= '0;
      train_start_o <= '0;
      train_done_o <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        dis_q[p] <= link_ctl_i[p].link_disable;
        train_start_o[p] <= dis_q[p] & !link_ctl_i[p].link_disable;
        // Training runs DLY cycles
        if (link_ctl_i[p].retrain || train_start_o[p]) cnt[p] <= DLY;
        else if (cnt[p] != 0) cnt[p] <= cnt[p] - 1;
        train_done_o[p] <= (cnt[p] == 1);
      end
    end
  end
endmodule : train_partner
